/* ppw_pkg.sv */
// shared constants, register map and types for the protection/warning monitor
package ppw_pkg;
    // register offsets on the register port
    localparam logic [7:0] ADDR_CUR_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_PROT_LVL  = 8'h09;
    localparam logic [7:0] ADDR_RAMP      = 8'h0a;
    localparam logic [7:0] ADDR_PG_DELAY  = 8'h0b;
    localparam logic [7:0] ADDR_PG_CFG    = 8'h0c;
    localparam logic [7:0] ADDR_STATUS    = 8'h0d;

    // reset values
    localparam logic [7:0] RST_CUR_LIMIT = 8'h1b;
    localparam logic [7:0] RST_PROT_LVL  = 8'h08;
    localparam logic [7:0] RST_RAMP      = 8'h11;
    localparam logic [7:0] RST_PG_DELAY  = 8'h00;
    localparam logic [7:0] RST_PG_CFG    = 8'h00;

    // current_limit_and_droop fields
    localparam int          DROOP_LSB   = 5;
    localparam int          TCOMP_BIT   = 4;
    localparam int          CL_LSB      = 0;
    localparam logic [3:0]  CL_CODE_MAX = 4'hb;
    // protection_level_config fields
    localparam int          PGHI_BIT    = 5;
    localparam int          PGLO_BIT    = 4;
    localparam int          OV_LSB      = 2;
    localparam int          UV_LSB      = 0;
    localparam logic [7:0]  PROT_MASK   = 8'h3f;
    // ramp register fields
    localparam int          RISE_LSB    = 4;
    localparam int          FALL_LSB    = 0;
    localparam logic [7:0]  RAMP_MASK   = 8'h77;
    // power-good configuration and status fields
    localparam int          PG_OFF_AT_RAMP_BIT = 0;
    localparam int          ST_PG_BIT   = 0;
    localparam int          ST_TW_BIT   = 1;

    // percentages of the active setpoint
    localparam logic [7:0] PCT_PG_HI_105 = 8'd105;
    localparam logic [7:0] PCT_PG_HI_110 = 8'd110;
    localparam logic [7:0] PCT_PG_LO_95  = 8'd95;
    localparam logic [7:0] PCT_PG_LO_90  = 8'd90;
    localparam logic [7:0] PCT_OV_0      = 8'd110;
    localparam logic [7:0] PCT_OV_1      = 8'd120;
    localparam logic [7:0] PCT_OV_2      = 8'd130;
    localparam logic [7:0] PCT_UV_0      = 8'd85;
    localparam logic [7:0] PCT_UV_1      = 8'd80;
    localparam logic [7:0] PCT_UV_2      = 8'd75;
    localparam logic [7:0] PCT_UV_3      = 8'd70;
    localparam logic [16:0] PCT_DIV      = 17'd100;

    // thermal warning thresholds in degrees C
    localparam logic [7:0] TEMP_WARN_ON  = 8'd120;
    localparam logic [7:0] TEMP_WARN_OFF = 8'd117;

    // timing
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         MS_NS         = 1000000;
    localparam int         CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam logic [7:0] PG_DLY_MAX_MS = 8'd150;

    localparam int THR_W = 17;

    typedef struct packed {
        logic [THR_W-1:0] ov;
        logic [THR_W-1:0] uv;
        logic [THR_W-1:0] pg_hi;
        logic [THR_W-1:0] pg_lo;
    } ppw_thr_t;

    typedef enum logic [3:0] {
        PG_OFF   = 4'b0001,
        PG_DELAY = 4'b0010,
        PG_GOOD  = 4'b0100,
        PG_WARN  = 4'b1000
    } ppw_pg_state_t;
endpackage

/* ppw_monitor.sv */
// protection thresholds, current-limit settings and warning logic
//
// What this block does
// R1 - fall ramp rate selectable independently of rise
// R2 - power-good window 105/110 high, 90/95 low
// R3 - bit 5 picks 105 or 110 percent
// R4 - bits 3:2 pick overvoltage 110 to 130 percent
// R5 - thresholds scale with the active setpoint
// R6 - bits 7:5 pick one of eight droops
// R7 - software keeps droop bits when changing limit
// R8 - bit 4 enables limit temperature compensation
// R9 - bits 3:0 set stationary or falling limit
// R10 - code 0xB default, higher codes become 0xB
// R11 - warnings never shut the output down
// R12 - above 120 C raise thermal warning
// R13 - clear thermal warning only below 117 C
// R14 - drive power-good low outside the window
// R15 - check power-good only after steady state
// R16 - hold power-good release 0 to 150 ms
// R17 - keep checking through margin transitions
// R18 - out-of-window warning pulls pin low, status bit 0
// R19 - back in window releases pin, restores bit
// R20 - external pull-down counts as power-good warning
// R21 - power-good drops at command or at ramp
// R22 - power manager polls status continuously
`timescale 1ns/1ps

module ppw_monitor #(
    parameter int CYC_PER_MS = ppw_pkg::CYC_PER_MS
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // register port as decoded from the management link
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_we,
    input  wire logic                    reg_re,
    output logic      [7:0]              reg_rdata,
    // converter state
    input  wire logic [15:0]             vout_setpoint,
    input  wire logic [15:0]             vout_meas,
    input  wire logic [7:0]              temp_c,
    input  wire logic                    steady_state,
    input  wire logic                    turnoff_cmd,
    input  wire logic                    ramp_down,
    // open-collector power-good pin
    input  wire logic                    pg_pin_in,
    output logic                         pg_pin_out,
    output logic                         pg_pin_oe,
    // settings toward the power stage
    output ppw_pkg::ppw_thr_t            thr,
    output logic [2:0]                   droop_select,
    output logic                         limit_temp_comp_enable,
    output logic [3:0]                   current_limit_code,
    output logic [2:0]                   rise_rate,
    output logic [2:0]                   fall_rate,
    output logic                         thermal_warning_flag,
    output logic                         power_good
);

    // percent of setpoint, rounded down
    function automatic logic [ppw_pkg::THR_W-1:0] pct_of(
        input logic [15:0] sp,
        input logic [7:0]  pct
    );
        logic [23:0] prod;
        logic [23:0] quot;
        prod = sp * pct;
        quot = prod / 24'(ppw_pkg::PCT_DIV);
        return quot[ppw_pkg::THR_W-1:0];
    endfunction

    // ---------------- reset release ----------------
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n_i;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n_i = rst_sync_q;

    // ---------------- registers ----------------
    logic [7:0] cur_limit_q;
    logic [7:0] prot_lvl_q;
    logic [7:0] ramp_q;
    logic [7:0] pg_delay_q;
    logic [7:0] pg_cfg_q;
    logic [7:0] rdata_q;

    wire        wr_cur   = reg_we && (reg_addr == ppw_pkg::ADDR_CUR_LIMIT);
    wire        wr_prot  = reg_we && (reg_addr == ppw_pkg::ADDR_PROT_LVL);
    wire        wr_ramp  = reg_we && (reg_addr == ppw_pkg::ADDR_RAMP);
    wire        wr_pgdly = reg_we && (reg_addr == ppw_pkg::ADDR_PG_DELAY);
    wire        wr_pgcfg = reg_we && (reg_addr == ppw_pkg::ADDR_PG_CFG);

    // the limit code is clamped on the way in so read-back shows the
    // code really in force
    wire [3:0]  wr_cl_raw  = reg_wdata[ppw_pkg::CL_LSB +: 4];
    wire [3:0]  wr_cl_code = (wr_cl_raw > ppw_pkg::CL_CODE_MAX) ?
                             ppw_pkg::CL_CODE_MAX : wr_cl_raw; // R10
    // droop bits come from the write as given; keeping them is up to
    // software
    wire [7:0]  cur_limit_d = {reg_wdata[ppw_pkg::TCOMP_BIT +: 4],
                               wr_cl_code}; // R7
    wire [7:0]  pg_delay_d  = (reg_wdata > ppw_pkg::PG_DLY_MAX_MS) ?
                              ppw_pkg::PG_DLY_MAX_MS : reg_wdata; // R16

    always_ff @(posedge clk_sys or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_limit_q <= ppw_pkg::RST_CUR_LIMIT; // R10
            prot_lvl_q  <= ppw_pkg::RST_PROT_LVL;
            ramp_q      <= ppw_pkg::RST_RAMP;
            pg_delay_q  <= ppw_pkg::RST_PG_DELAY;
            pg_cfg_q    <= ppw_pkg::RST_PG_CFG;
        end else begin
            if (wr_cur)
                cur_limit_q <= cur_limit_d; // R9
            if (wr_prot)
                prot_lvl_q <= reg_wdata & ppw_pkg::PROT_MASK;
            if (wr_ramp)
                ramp_q <= reg_wdata & ppw_pkg::RAMP_MASK; // R1
            if (wr_pgdly)
                pg_delay_q <= pg_delay_d;
            if (wr_pgcfg)
                pg_cfg_q <= {7'h00, reg_wdata[ppw_pkg::PG_OFF_AT_RAMP_BIT]};
        end
    end

    // ---------------- threshold selection ----------------
    wire        pg_hi_105 = prot_lvl_q[ppw_pkg::PGHI_BIT];
    wire        pg_lo_95  = prot_lvl_q[ppw_pkg::PGLO_BIT];
    wire [1:0]  ov_sel    = prot_lvl_q[ppw_pkg::OV_LSB +: 2];
    wire [1:0]  uv_sel    = prot_lvl_q[ppw_pkg::UV_LSB +: 2];

    wire [7:0]  pct_pg_hi = pg_hi_105 ? ppw_pkg::PCT_PG_HI_105
                                      : ppw_pkg::PCT_PG_HI_110; // R3
    wire [7:0]  pct_pg_lo = pg_lo_95  ? ppw_pkg::PCT_PG_LO_95
                                      : ppw_pkg::PCT_PG_LO_90; // R2
    wire [7:0]  pct_ov    = (ov_sel == 2'b00) ? ppw_pkg::PCT_OV_0 :
                            (ov_sel == 2'b01) ? ppw_pkg::PCT_OV_1 :
                                                ppw_pkg::PCT_OV_2; // R4
    wire [7:0]  pct_uv    = (uv_sel == 2'b00) ? ppw_pkg::PCT_UV_0 :
                            (uv_sel == 2'b01) ? ppw_pkg::PCT_UV_1 :
                            (uv_sel == 2'b10) ? ppw_pkg::PCT_UV_2 :
                                                ppw_pkg::PCT_UV_3;

    // recomputed every cycle from the live setpoint, so margining moves
    // all four levels together
    ppw_pkg::ppw_thr_t thr_d;
    ppw_pkg::ppw_thr_t thr_q;
    assign thr_d.ov    = pct_of(vout_setpoint, pct_ov); // R5
    assign thr_d.uv    = pct_of(vout_setpoint, pct_uv); // R5
    assign thr_d.pg_hi = pct_of(vout_setpoint, pct_pg_hi); // R5
    assign thr_d.pg_lo = pct_of(vout_setpoint, pct_pg_lo); // R5

    always_ff @(posedge clk_sys or negedge rst_n_i) begin
        if (!rst_n_i)
            thr_q <= '0;
        else
            thr_q <= thr_d;
    end

    // window uses last cycle's levels: one cycle of lag on a setpoint
    // step, traded for a short compare path
    wire [ppw_pkg::THR_W-1:0] vmeas_w = {1'b0, vout_meas};
    wire in_window = (vmeas_w <= thr_q.pg_hi) &&
                     (vmeas_w >= thr_q.pg_lo); // R14

    // ---------------- thermal warning ----------------
    logic tw_q;
    wire  tw_set = temp_c > ppw_pkg::TEMP_WARN_ON; // R12
    wire  tw_clr = temp_c < ppw_pkg::TEMP_WARN_OFF; // R13
    // between the two levels the flag keeps its value: the hysteresis
    wire  tw_d   = tw_set ? 1'b1 : (tw_clr ? 1'b0 : tw_q);

    always_ff @(posedge clk_sys or negedge rst_n_i) begin
        if (!rst_n_i)
            tw_q <= 1'b0;
        else
            tw_q <= tw_d; // R12
    end

    // ---------------- power-good release delay ----------------
    logic [16:0] ms_cnt_q;
    logic [7:0]  ms_elapsed_q;
    ppw_pkg::ppw_pg_state_t pg_st_q;
    ppw_pkg::ppw_pg_state_t pg_st_d;

    // the count only runs in the delay state, so every turn-on waits in full
    wire        in_delay   = (pg_st_q == ppw_pkg::PG_DELAY);
    wire        ms_tick    = in_delay &&
                             (ms_cnt_q == 17'(CYC_PER_MS - 1));
    wire        delay_done = (ms_elapsed_q >= pg_delay_q); // R16

    always_ff @(posedge clk_sys or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ms_cnt_q     <= '0;
            ms_elapsed_q <= '0;
        end else if (!in_delay) begin
            ms_cnt_q     <= '0;
            ms_elapsed_q <= '0;
        end else if (ms_tick) begin
            ms_cnt_q     <= '0;
            ms_elapsed_q <= delay_done ? ms_elapsed_q : ms_elapsed_q + 8'd1;
        end else begin
            ms_cnt_q     <= ms_cnt_q + 17'd1;
        end
    end

    // ---------------- power-good state machine ----------------
    wire off_at_ramp = pg_cfg_q[ppw_pkg::PG_OFF_AT_RAMP_BIT];
    wire pg_turnoff  = off_at_ramp ? ramp_down : turnoff_cmd; // R21

    always_comb begin
        pg_st_d = pg_st_q;
        case (pg_st_q)
            ppw_pkg::PG_OFF: begin
                if (steady_state && !turnoff_cmd && !ramp_down)
                    pg_st_d = ppw_pkg::PG_DELAY; // R15
            end
            ppw_pkg::PG_DELAY: begin
                if (pg_turnoff || !steady_state)
                    pg_st_d = ppw_pkg::PG_OFF;
                else if (delay_done && in_window)
                    pg_st_d = ppw_pkg::PG_GOOD; // R16
            end
            ppw_pkg::PG_GOOD: begin
                if (pg_turnoff)
                    pg_st_d = ppw_pkg::PG_OFF; // R21
                else if (!in_window || !pg_pin_in)
                    pg_st_d = ppw_pkg::PG_WARN; // R17 R20
            end
            ppw_pkg::PG_WARN: begin
                if (pg_turnoff)
                    pg_st_d = ppw_pkg::PG_OFF;
                else if (in_window && pg_pin_in)
                    pg_st_d = ppw_pkg::PG_GOOD; // R19
            end
            default: pg_st_d = ppw_pkg::PG_OFF;
        endcase
    end

    // in the warning state the pin is only driven while out of window;
    // otherwise it is let go so an outside pull-down can be seen leaving
    logic pg_oe_d;
    assign pg_oe_d = (pg_st_d == ppw_pkg::PG_OFF)   ||
                     (pg_st_d == ppw_pkg::PG_DELAY) ||
                     ((pg_st_d == ppw_pkg::PG_WARN) && !in_window); // R18

    logic pg_oe_q;
    logic pg_good_q;

    always_ff @(posedge clk_sys or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pg_st_q   <= ppw_pkg::PG_OFF;
            pg_oe_q   <= 1'b1;
            pg_good_q <= 1'b0;
        end else begin
            pg_st_q   <= pg_st_d;
            pg_oe_q   <= pg_oe_d; // R14
            pg_good_q <= (pg_st_d == ppw_pkg::PG_GOOD); // R18 R19
        end
    end

    // ---------------- status and read-back ----------------
    // both warnings read as 0 while active; nothing here reaches the
    // power stage, so a warning never turns the output off
    logic [7:0] status_w; // R11
    always_comb begin
        status_w = 8'h00;
        status_w[ppw_pkg::ST_PG_BIT] = pg_good_q; // R18 R19
        status_w[ppw_pkg::ST_TW_BIT] = ~tw_q; // R12 R13
    end

    wire [7:0] rdata_d =
        (reg_addr == ppw_pkg::ADDR_CUR_LIMIT) ? cur_limit_q :
        (reg_addr == ppw_pkg::ADDR_PROT_LVL)  ? prot_lvl_q  :
        (reg_addr == ppw_pkg::ADDR_RAMP)      ? ramp_q      :
        (reg_addr == ppw_pkg::ADDR_PG_DELAY)  ? pg_delay_q  :
        (reg_addr == ppw_pkg::ADDR_PG_CFG)    ? pg_cfg_q    :
        (reg_addr == ppw_pkg::ADDR_STATUS)    ? status_w    : 8'h00;

    always_ff @(posedge clk_sys or negedge rst_n_i) begin
        if (!rst_n_i)
            rdata_q <= 8'h00;
        else if (reg_re)
            rdata_q <= rdata_d;
    end

    // ---------------- registered settings out ----------------
    logic [2:0] droop_q;
    logic       tcomp_q;
    logic [3:0] cl_q;
    logic [2:0] rise_q;
    logic [2:0] fall_q;

    // settings leave reset at their register defaults, so the stage
    // never runs with a minimum limit while the registers come up
    always_ff @(posedge clk_sys or negedge rst_n_i) begin
        if (!rst_n_i) begin
            droop_q <= ppw_pkg::RST_CUR_LIMIT[ppw_pkg::DROOP_LSB +: 3];
            tcomp_q <= ppw_pkg::RST_CUR_LIMIT[ppw_pkg::TCOMP_BIT]; // R8
            cl_q    <= ppw_pkg::RST_CUR_LIMIT[ppw_pkg::CL_LSB +: 4]; // R10
            rise_q  <= ppw_pkg::RST_RAMP[ppw_pkg::RISE_LSB +: 3];
            fall_q  <= ppw_pkg::RST_RAMP[ppw_pkg::FALL_LSB +: 3];
        end else begin
            droop_q <= cur_limit_q[ppw_pkg::DROOP_LSB +: 3]; // R6
            tcomp_q <= cur_limit_q[ppw_pkg::TCOMP_BIT]; // R8
            cl_q    <= cur_limit_q[ppw_pkg::CL_LSB +: 4]; // R9
            rise_q  <= ramp_q[ppw_pkg::RISE_LSB +: 3];
            fall_q  <= ramp_q[ppw_pkg::FALL_LSB +: 3]; // R1
        end
    end

    // open collector: the level is always low, only the enable moves
    logic pg_out_q;
    always_ff @(posedge clk_sys or negedge rst_n_i) begin
        if (!rst_n_i)
            pg_out_q <= 1'b0;
        else
            pg_out_q <= 1'b0;
    end

    assign reg_rdata              = rdata_q;
    assign pg_pin_out             = pg_out_q;
    assign pg_pin_oe              = pg_oe_q;
    assign thr                    = thr_q;
    assign droop_select           = droop_q;
    assign limit_temp_comp_enable = tcomp_q;
    assign current_limit_code     = cl_q;
    assign rise_rate              = rise_q;
    assign fall_rate              = fall_q;
    assign thermal_warning_flag   = tw_q;
    assign power_good             = pg_good_q;

endmodule // ppw_monitor

/* ppw_monitor_monitor.sv */
// assertion checker bound to the protection/warning monitor ports
`timescale 1ns/1ps

module ppw_monitor_chk (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_we,
    input wire logic              reg_re,
    input wire logic [7:0]        reg_rdata,
    input wire logic [15:0]       vout_meas,
    input wire logic [7:0]        temp_c,
    input wire logic              steady_state,
    input wire logic              pg_pin_in,
    input wire logic              pg_pin_out,
    input wire logic              pg_pin_oe,
    input wire ppw_pkg::ppw_thr_t thr,
    input wire logic [2:0]        droop_select,
    input wire logic              limit_temp_comp_enable,
    input wire logic [3:0]        current_limit_code,
    input wire logic              thermal_warning_flag,
    input wire logic              power_good
);
    // the design holds its own reset two edges longer, so wait it out
    logic [1:0] up_q;
    logic       live;
    assign live = (up_q == 2'd3);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            up_q <= 2'd0;
        else if (!live)
            up_q <= up_q + 2'd1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    warn_rise_a: assert property (
        live && temp_c > 8'd120 |=> thermal_warning_flag)
        else $error("thermal flag not raised when hot");
    warn_clear_a: assert property (
        live && temp_c < 8'd117 |=> !thermal_warning_flag)
        else $error("thermal flag not cleared when cool");
    warn_hold_a: assert property (
        live && temp_c >= 8'd117 && temp_c <= 8'd120
        |=> $stable(thermal_warning_flag))
        else $error("thermal flag moved inside hysteresis band");
    status_bits_a: assert property (
        live && reg_re && reg_addr == ppw_pkg::ADDR_STATUS
        |=> reg_rdata[ppw_pkg::ST_TW_BIT] == !$past(thermal_warning_flag)
            && reg_rdata[ppw_pkg::ST_PG_BIT] == $past(power_good))
        else $error("status bits disagree with warnings");
    limit_clamp_a: assert property (
        live && reg_we && reg_addr == ppw_pkg::ADDR_CUR_LIMIT |=> ##1
        current_limit_code == (($past(reg_wdata[3:0], 2) > 4'hb) ?
            4'hb : $past(reg_wdata[3:0], 2)))
        else $error("current limit code not clamped");
    droop_copy_a: assert property (
        live && reg_we && reg_addr == ppw_pkg::ADDR_CUR_LIMIT |=> ##1
        droop_select == $past(reg_wdata[7:5], 2)
        && limit_temp_comp_enable == $past(reg_wdata[4], 2))
        else $error("droop or compensation field not applied");
    good_steady_a: assert property (
        live && $rose(power_good) |-> $past(steady_state))
        else $error("power good before steady state");
    good_pin_a: assert property (
        power_good |-> !pg_pin_oe && !pg_pin_out)
        else $error("pin held low while good");
    window_drop_a: assert property (
        live && power_good && ({1'b0, vout_meas} > thr.pg_hi
        || {1'b0, vout_meas} < thr.pg_lo) |=> !power_good && pg_pin_oe)
        else $error("out of window not flagged");
    ext_pull_a: assert property (
        live && power_good && !pg_pin_in |=> !power_good)
        else $error("external pull-down not flagged");
endmodule // ppw_monitor_chk

bind ppw_monitor ppw_monitor_chk u_chk (.clk_sys, .rst_n, .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata, .vout_meas, .temp_c,
    .steady_state, .pg_pin_in, .pg_pin_out, .pg_pin_oe, .thr,
    .droop_select, .limit_temp_comp_enable, .current_limit_code,
    .thermal_warning_flag, .power_good);

/* ppw_host_model.sv */
// power manager model: register writes, reads and status polling
`timescale 1ns/1ps

module ppw_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_we,
    output logic            reg_re
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
    end
    // strobes move on falling edges, so each is exactly one cycle wide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_we    = 1'b1;
        @(negedge clk_sys);
        reg_we    = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_re   = 1'b1;
        @(negedge clk_sys);
        reg_re   = 1'b0;
        d        = reg_rdata;
    endtask
    task automatic poll(output logic [7:0] d);
        rd(ppw_pkg::ADDR_STATUS, d);
    endtask
    // a limit change must not disturb droop or compensation
    task automatic set_limit(input logic [3:0] code);
        logic [7:0] v;
        rd(ppw_pkg::ADDR_CUR_LIMIT, v);
        wr(ppw_pkg::ADDR_CUR_LIMIT, {v[7:4], code});
    endtask
endmodule // ppw_host_model

/* testbench.sv */
// self-checking bench for the protection/warning monitor
`timescale 1ns/1ps

module testbench;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata, rv;
    logic              reg_we, reg_re, pg_pin_out, pg_pin_oe, pg_wire;
    logic [15:0]       vout_setpoint = 16'd1000;
    logic [15:0]       vout_meas = 16'd0;
    logic [7:0]        temp_c = 8'd25;
    logic              steady_state = 1'b0;
    logic              turnoff_cmd = 1'b0;
    logic              ramp_down = 1'b0;
    logic              ext_pull = 1'b0;
    ppw_pkg::ppw_thr_t thr;
    logic [2:0]        droop_select, rise_rate, fall_rate;
    logic              limit_temp_comp_enable, thermal_warning_flag;
    logic              power_good;
    logic [3:0]        current_limit_code;
    int                miscompares = 0, checked = 0, cycles = 0, n;
    logic [7:0]        pv[3] = '{8'hf5, 8'h0e, 8'h03};
    int                ovp[3] = '{120, 130, 110}, uvp[3] = '{80, 75, 70};
    int                hip[3] = '{105, 110, 110}, lop[3] = '{95, 90, 90};

    always #5 clk_sys = ~clk_sys;
    // open collector wire with pull-up
    assign pg_wire = !(pg_pin_oe || ext_pull);

    ppw_monitor #(.CYC_PER_MS(10)) dut (.clk_sys, .rst_n, .reg_addr,
        .reg_wdata, .reg_we, .reg_re, .reg_rdata, .vout_setpoint,
        .vout_meas, .temp_c, .steady_state, .turnoff_cmd, .ramp_down,
        .pg_pin_in(pg_wire), .pg_pin_out, .pg_pin_oe, .thr, .droop_select,
        .limit_temp_comp_enable, .current_limit_code, .rise_rate,
        .fall_rate, .thermal_warning_flag, .power_good);
    ppw_host_model host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata,
        .reg_we, .reg_re);

    task automatic close_out();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic chk_thr(input int sp, input int ov, input int uv,
                           input int hi, input int lo);
        chk(thr.ov, 17'(sp * ov / 100));
        chk(thr.uv, 17'(sp * uv / 100));
        chk(thr.pg_hi, 17'(sp * hi / 100));
        chk(thr.pg_lo, 17'(sp * lo / 100));
    endtask
    task automatic wait_pg(input logic v, input int lim);
        n = 0;
        while (power_good !== v && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    // run is about 150 cycles; the ceiling only catches a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        settle(4);
        rst_n = 1'b1;
        settle(4);
        chk_rd(ppw_pkg::ADDR_CUR_LIMIT, 8'h1b);
        chk_rd(ppw_pkg::ADDR_PROT_LVL, 8'h08);
        chk_rd(ppw_pkg::ADDR_RAMP, 8'h11);
        chk_rd(ppw_pkg::ADDR_PG_DELAY, 8'h00);
        chk_rd(8'h20, 8'h00);
        chk_rd(ppw_pkg::ADDR_STATUS, 8'h02);
        $display("test reset_values done");
        host.wr(ppw_pkg::ADDR_CUR_LIMIT, 8'hef);
        chk_rd(ppw_pkg::ADDR_CUR_LIMIT, 8'heb);
        chk(current_limit_code, 4'hb);
        chk(droop_select, 3'd7);
        chk(limit_temp_comp_enable, 1'b0);
        host.set_limit(4'h0);
        chk_rd(ppw_pkg::ADDR_CUR_LIMIT, 8'he0);
        host.wr(ppw_pkg::ADDR_RAMP, 8'hd3);
        chk_rd(ppw_pkg::ADDR_RAMP, 8'h53);
        chk(rise_rate, 3'd5);
        chk(fall_rate, 3'd3);
        $display("test limits_and_ramps done");
        chk_thr(1000, 130, 85, 110, 90);
        for (int i = 0; i < 3; i++) begin
            host.wr(ppw_pkg::ADDR_PROT_LVL, pv[i]);
            settle(2);
            chk_thr(1000, ovp[i], uvp[i], hip[i], lop[i]);
        end
        chk_rd(ppw_pkg::ADDR_PROT_LVL, 8'h03);
        vout_setpoint = 16'd1100;
        settle(3);
        chk_thr(1100, 110, 70, 110, 90);
        vout_setpoint = 16'd1000;
        $display("test thresholds done");
        host.wr(ppw_pkg::ADDR_PG_DELAY, 8'hff);
        chk_rd(ppw_pkg::ADDR_PG_DELAY, 8'd150);
        host.wr(ppw_pkg::ADDR_PG_DELAY, 8'd2);
        vout_meas = 16'd1000;
        settle(5);
        chk(power_good, 1'b0);
        steady_state = 1'b1;
        settle(2);
        chk(pg_wire, 1'b0);
        wait_pg(1'b1, 60);
        chk(n >= 18 && n <= 22, 1'b1);
        temp_c = 8'd121;
        settle(2);
        chk(thermal_warning_flag, 1'b1);
        chk(power_good, 1'b1);
        host.poll(rv);
        chk(rv, 8'h01);
        temp_c = 8'd118;
        settle(3);
        chk(thermal_warning_flag, 1'b1);
        temp_c = 8'd116;
        settle(2);
        chk(thermal_warning_flag, 1'b0);
        vout_meas = 16'd1101;
        settle(2);
        chk(pg_wire, 1'b0);
        chk_rd(ppw_pkg::ADDR_STATUS, 8'h02);
        vout_meas = 16'd950;
        wait_pg(1'b1, 10);
        chk(pg_wire, 1'b1);
        vout_meas = 16'd899;
        settle(2);
        chk(power_good, 1'b0);
        vout_meas = 16'd1050;
        wait_pg(1'b1, 10);
        ext_pull = 1'b1;
        settle(2);
        chk(power_good, 1'b0);
        chk(pg_pin_oe, 1'b0);
        ext_pull = 1'b0;
        wait_pg(1'b1, 10);
        chk(power_good, 1'b1);
        vout_setpoint = 16'd1100;
        settle(2);
        vout_meas = 16'd1150;
        settle(4);
        chk(power_good, 1'b1);
        turnoff_cmd = 1'b1;
        settle(2);
        chk(power_good, 1'b0);
        turnoff_cmd = 1'b0;
        wait_pg(1'b1, 60);
        host.wr(ppw_pkg::ADDR_PG_CFG, 8'h01);
        turnoff_cmd = 1'b1;
        settle(3);
        chk(power_good, 1'b1);
        ramp_down = 1'b1;
        settle(2);
        chk(power_good, 1'b0);
        $display("test power_good done");
        close_out();
    end
endmodule // testbench
